/* hdl/vpc_pkg.sv */
// constants, states and commands of the push-button volume control
// assumes a single 25 MHz system clock and no other clock domain
`default_nettype none
package vpc_pkg;
  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int MS_NS           = 1_000_000;
  localparam int TICK_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int ACT_RISE_NS     = 1_000;
  localparam int ACT_RISE_CYCLES =
    (ACT_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // intervals in ms ticks
  // ----------------------------------------------------------------
  localparam int POWERUP_MS      = 10;
  localparam int DEBOUNCE_MS     = 20;
  localparam int LOCKOUT_MS      = 40;
  localparam int ZC_WINDOW_MS    = 32;
  localparam int AUTO_START_S    = 1;
  localparam int AUTO_START_MS   = AUTO_START_S * 1000;
  localparam int SLOW_HZ         = 4;
  localparam int FAST_HZ         = 8;
  localparam int SLOW_PERIOD_MS  = 1000 / SLOW_HZ;
  localparam int FAST_PERIOD_MS  = 1000 / FAST_HZ;
  localparam int SLOW_SPAN_S     = 4;
  localparam int FAST_START_MS   = AUTO_START_MS + SLOW_SPAN_S * 1000;
  localparam int ACT_FALL_STEP_S = 30;
  localparam int ACT_FALL_STEP_MS = ACT_FALL_STEP_S * 1000;
  // ----------------------------------------------------------------
  // tap codes
  // ----------------------------------------------------------------
  localparam int TAP_W = 6;
  localparam logic [TAP_W-1:0] TAP_TOP   = 6'h00;
  localparam logic [TAP_W-1:0] TAP_MUTE  = 6'h20;
  localparam logic [TAP_W-1:0] TAP_RESET = 6'h0a;
  localparam logic [TAP_W-1:0] TAP_PARK  = 6'h20;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_POWERUP = 3'b000,
    S_IDLE    = 3'b001,
    S_DISCARD = 3'b010,
    S_ZWAIT   = 3'b011,
    S_LOCK    = 3'b100,
    S_HOLD    = 3'b101
  } vpc_state_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_INC  = 2'b01,
    CMD_DEC  = 2'b10,
    CMD_MUTE = 2'b11
  } vpc_cmd_t;
endpackage
`default_nettype wire

/* hdl/vpc_debounce.sv */
// one button: synchroniser and low-level debounce filter
// assumes a one-cycle ms tick from the same clock domain
`default_nettype none
module vpc_debounce (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic button_n,
  output logic      pressed
);
  logic       s1;
  logic       s2;
  logic [4:0] cnt;
  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
    end
    else
    begin
      s1 <= button_n;
      s2 <= s1;
    end
  end
  // ----------------------------------------------------------------
  // filter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || s2)
    begin
      cnt     <= 5'h00;
      pressed <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt == 5'(vpc_pkg::DEBOUNCE_MS - 1))
        pressed <= 1'b1;
      else
        cnt <= cnt + 5'h01;
    end
  end
endmodule
`default_nettype wire

/* hdl/vpc_activity.sv */
// audio activity flag with fast rise and programmable fall delay
// assumes threshold comparator outputs arrive asynchronously
`default_nettype none
module vpc_activity #(
  parameter int RISE_CYCLES = vpc_pkg::ACT_RISE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       above_left,
  input  wire logic       above_right,
  input  wire logic [2:0] sel,
  output logic            active
);
  logic [1:0]  s1;
  logic [1:0]  s2;
  logic [5:0]  rise_cnt;
  logic [17:0] fall_ms;
  function automatic logic [17:0] fall_limit(input logic [2:0] code);
    fall_limit = 18'((int'(code) + 1) * vpc_pkg::ACT_FALL_STEP_MS);
  endfunction
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= 2'h0;
      s2 <= 2'h0;
    end
    else
    begin
      s1 <= {above_right, above_left};
      s2 <= s1;
    end
  end
  // ----------------------------------------------------------------
  // rise and fall timing
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rise_cnt <= 6'h00;
      fall_ms  <= 18'h0_0000;
      active   <= 1'b0;
    end
    else if (|s2)
    begin
      fall_ms <= 18'h0_0000;
      if (rise_cnt == 6'(RISE_CYCLES - 1))
        active <= 1'b1;
      else
        rise_cnt <= rise_cnt + 6'h01;
    end
    else
    begin
      rise_cnt <= 6'h00;
      if (sel == 3'h0)
        active <= 1'b0;
      else if (tick)
      begin
        if (fall_ms >= fall_limit(sel) - 18'h0_0001)
          active <= 1'b0;
        else
          fall_ms <= fall_ms + 18'h0_0001;
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/vpc_top.sv */
// push-button stereo volume control: buttons, tap counter, wipers
// assumes buttons and analog comparator outputs are asynchronous pins
// Contract
// - validated increment press moves both wipers one tap up
// - increment held 1s auto-steps at 4Hz for 4s, then 8Hz
// - at top tap increments are ignored, no wrap
// - validated decrement press moves both wipers one tap down
// - decrement held 1s auto-steps at 4Hz for 4s, then 8Hz
// - at mute bottom decrement is ignored, and mute too unless muted by mute
// - first mute moves both wipers to mute tap, remembering old tap
// - second mute restores the remembered tap
// - standby low disconnects arrays, parks wipers, low power
// - leaving standby restores the wipers held before
// - activity high while either input is above threshold
// - activity rises about 1us after detection, no delay
// - 3-bit select sets fall delay: 0, 60s, +30s up to 240s
// - press to tap change about 20ms incl. debounce, zero wait
// - 40ms lockout after validation ignores new commands
// - change at zero crossing within 32ms or at window end
// - reset presets wipers to tap 10, settles within 10ms
// - each channel waits for its own zero crossing
// - simultaneous presses are discarded after all released
// - tap held in a counter decoded to one tap
`default_nettype none
module vpc_top #(
  parameter int TICK_CYCLES = vpc_pkg::TICK_CYCLES
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic [7:0]                WB_ADR_I,
  input  wire logic [31:0]               WB_DAT_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic                      WB_WE_I,
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  output logic      [31:0]               WB_DAT_O,
  output logic                           WB_ACK_O,
  input  wire logic                      INC_BUTTON_N,
  input  wire logic                      DECREMENT_BUTTON_N,
  input  wire logic                      MUTE_BUTTON_N,
  input  wire logic                      STANDBY_N,
  input  wire logic                      LEFT_ZERO_CROSS,
  input  wire logic                      RIGHT_ZERO_CROSS,
  input  wire logic                      LEFT_ABOVE_THRESHOLD,
  input  wire logic                      RIGHT_ABOVE_THRESHOLD,
  output logic      [vpc_pkg::TAP_W-1:0] LEFT_TAP,
  output logic      [vpc_pkg::TAP_W-1:0] RIGHT_TAP,
  output logic                           ARRAY_CONNECT,
  output logic                           LOW_POWER,
  output logic                           ACTIVITY
);
  localparam int TW = vpc_pkg::TAP_W;
  logic [15:0]              tick_cnt;
  logic                     tick;
  logic [2:0]               pressed;
  logic [2:0]               buttons_n;
  logic [1:0]               sb_sync;
  logic [1:0]               zc1;
  logic [1:0]               zc2;
  logic                     stby;
  vpc_pkg::vpc_state_t      state;
  vpc_pkg::vpc_cmd_t        cmd;
  logic [TW-1:0]            tap;
  logic [TW-1:0]            saved;
  logic                     muted;
  logic [TW-1:0]            wiper [2];
  logic [1:0]               pend;
  logic                     launch;
  logic [5:0]               win_ms;
  logic [5:0]               lock_ms;
  logic [12:0]              hold_ms;
  logic [12:0]              due;
  logic [3:0]               pu_ms;
  logic [2:0]               delay_sel;
  logic                     multi;
  logic                     win_end;
  vpc_pkg::vpc_cmd_t        next_cmd;
  logic [TW-1:0]            next_tap;
  function automatic logic [TW-1:0] step_tap(
    input vpc_pkg::vpc_cmd_t c,
    input logic [TW-1:0]     t,
    input logic              m,
    input logic [TW-1:0]     s
  );
    step_tap = t;
    if (c == vpc_pkg::CMD_INC && t != vpc_pkg::TAP_TOP)
      step_tap = t - 6'h01;
    else if (c == vpc_pkg::CMD_DEC && t != vpc_pkg::TAP_MUTE)
      step_tap = t + 6'h01;
    else if (c == vpc_pkg::CMD_MUTE && m)
      step_tap = s;
    else if (c == vpc_pkg::CMD_MUTE && t != vpc_pkg::TAP_MUTE)
      step_tap = vpc_pkg::TAP_MUTE;
  endfunction
  // ----------------------------------------------------------------
  // ms timebase and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || tick_cnt == 16'(TICK_CYCLES - 1))
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
    tick <= !SYS_RST && (tick_cnt == 16'(TICK_CYCLES - 1));
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      sb_sync <= 2'h3;
      zc1     <= 2'h0;
      zc2     <= 2'h0;
    end
    else
    begin
      sb_sync <= {sb_sync[0], STANDBY_N};
      zc1     <= {RIGHT_ZERO_CROSS, LEFT_ZERO_CROSS};
      zc2     <= zc1;
    end
  end
  assign stby      = !sb_sync[1];
  assign buttons_n = {MUTE_BUTTON_N, DECREMENT_BUTTON_N, INC_BUTTON_N};
  for (genvar b = 0; b < 3; b++)
  begin : g_btn
    vpc_debounce u_db (
      .clk      (SYS_CLK),
      .rst      (SYS_RST),
      .tick     (tick),
      .button_n (buttons_n[b]),
      .pressed  (pressed[b])
    );
  end
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    multi   = (pressed == 3'h3) || (pressed == 3'h5) ||
              (pressed == 3'h6) || (pressed == 3'h7);
    win_end = (win_ms >= 6'(vpc_pkg::ZC_WINDOW_MS));
    if (pressed[0])
      next_cmd = vpc_pkg::CMD_INC;
    else if (pressed[1])
      next_cmd = vpc_pkg::CMD_DEC;
    else if (pressed[2])
      next_cmd = vpc_pkg::CMD_MUTE;
    else
      next_cmd = vpc_pkg::CMD_NONE;
    if (state == vpc_pkg::S_HOLD)
      next_tap = step_tap(cmd, tap, muted, saved);
    else
      next_tap = step_tap(next_cmd, tap, muted, saved);
  end
  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      state   <= vpc_pkg::S_POWERUP;
      cmd     <= vpc_pkg::CMD_NONE;
      tap     <= vpc_pkg::TAP_RESET;
      saved   <= vpc_pkg::TAP_RESET;
      muted   <= 1'b0;
      launch  <= 1'b0;
      win_ms  <= 6'h00;
      lock_ms <= 6'h00;
      hold_ms <= 13'h0000;
      due     <= 13'(vpc_pkg::AUTO_START_MS);
      pu_ms   <= 4'h0;
    end
    else
    begin
      launch <= 1'b0;
      if (tick && !win_end)
        win_ms <= win_ms + 6'h01;
      if (tick && lock_ms < 6'(vpc_pkg::LOCKOUT_MS))
        lock_ms <= lock_ms + 6'h01;
      if (tick && hold_ms < 13'(vpc_pkg::FAST_START_MS))
        hold_ms <= hold_ms + 13'h0001;
      case (state)
        vpc_pkg::S_POWERUP:
        begin
          if (tick)
            pu_ms <= pu_ms + 4'h1;
          if (pu_ms == 4'(vpc_pkg::POWERUP_MS))
            state <= vpc_pkg::S_IDLE;
        end
        vpc_pkg::S_IDLE:
        begin
          if (multi)
            state <= vpc_pkg::S_DISCARD;
          else if (!stby && next_cmd != vpc_pkg::CMD_NONE)
          begin
            cmd     <= next_cmd;
            tap     <= next_tap;
            muted   <= (next_cmd == vpc_pkg::CMD_DEC) ? muted :
                       (next_cmd == vpc_pkg::CMD_MUTE) &&
                       (next_tap == vpc_pkg::TAP_MUTE) &&
                       (tap != vpc_pkg::TAP_MUTE);
            if (next_cmd == vpc_pkg::CMD_MUTE && !muted)
              saved <= tap;
            launch  <= 1'b1;
            win_ms  <= 6'h00;
            lock_ms <= 6'h00;
            hold_ms <= 13'h0000;
            due     <= 13'(vpc_pkg::AUTO_START_MS);
            state   <= vpc_pkg::S_ZWAIT;
          end
        end
        vpc_pkg::S_DISCARD:
        begin
          if (pressed == 3'h0)
            state <= vpc_pkg::S_IDLE;
        end
        vpc_pkg::S_ZWAIT:
        begin
          if (!launch && pend == 2'h0)
            state <= vpc_pkg::S_LOCK;
        end
        vpc_pkg::S_LOCK:
        begin
          if (multi)
            state <= vpc_pkg::S_DISCARD;
          else if (lock_ms >= 6'(vpc_pkg::LOCKOUT_MS))
            state <= vpc_pkg::S_HOLD;
        end
        vpc_pkg::S_HOLD:
        begin
          if (multi)
            state <= vpc_pkg::S_DISCARD;
          else if (pressed == 3'h0)
            state <= vpc_pkg::S_IDLE;
          else if (cmd != vpc_pkg::CMD_MUTE && hold_ms >= due)
          begin
            tap    <= next_tap;
            muted  <= muted && (cmd == vpc_pkg::CMD_DEC);
            launch <= 1'b1;
            win_ms <= 6'h00;
            state  <= vpc_pkg::S_ZWAIT;
            if (due < 13'(vpc_pkg::FAST_START_MS))
              due <= due + 13'(vpc_pkg::SLOW_PERIOD_MS);
            else
            begin
              hold_ms <= 13'(vpc_pkg::FAST_START_MS -
                             vpc_pkg::FAST_PERIOD_MS);
              due     <= 13'(vpc_pkg::FAST_START_MS);
            end
          end
        end
        default:
          state <= vpc_pkg::S_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // per-channel wipers
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    always_ff @(posedge SYS_CLK)
    begin
      if (SYS_RST)
      begin
        pend[ch]  <= 1'b0;
        wiper[ch] <= vpc_pkg::TAP_RESET;
      end
      else if (launch)
        pend[ch] <= 1'b1;
      else if (pend[ch] && (zc2[ch] || win_end))
      begin
        pend[ch]  <= 1'b0;
        wiper[ch] <= tap;
      end
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      LEFT_TAP      <= vpc_pkg::TAP_RESET;
      RIGHT_TAP     <= vpc_pkg::TAP_RESET;
      ARRAY_CONNECT <= 1'b1;
      LOW_POWER     <= 1'b0;
    end
    else
    begin
      LEFT_TAP      <= stby ? vpc_pkg::TAP_PARK : wiper[0];
      RIGHT_TAP     <= stby ? vpc_pkg::TAP_PARK : wiper[1];
      ARRAY_CONNECT <= !stby;
      LOW_POWER     <= stby;
    end
  end
  vpc_activity u_act (
    .clk         (SYS_CLK),
    .rst         (SYS_RST),
    .tick        (tick),
    .above_left  (LEFT_ABOVE_THRESHOLD),
    .above_right (RIGHT_ABOVE_THRESHOLD),
    .sel         (delay_sel),
    .active      (ACTIVITY)
  );
  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      WB_ACK_O  <= 1'b0;
      WB_DAT_O  <= 32'h0000_0000;
      delay_sel <= vpc_pkg::CTRL_RESET;
    end
    else
    begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      WB_DAT_O <= 32'h0000_0000;
      if (WB_CYC_I && WB_STB_I && !WB_ACK_O)
      begin
        if (WB_ADR_I == vpc_pkg::ADR_CTRL)
        begin
          WB_DAT_O <= {29'h0000_0000, delay_sel};
          if (WB_WE_I && WB_SEL_I[0])
            delay_sel <= WB_DAT_I[2:0];
        end
        else if (WB_ADR_I == vpc_pkg::ADR_STATUS)
          WB_DAT_O <= {22'h00_0000, state != vpc_pkg::S_IDLE, stby,
                       ACTIVITY, muted, tap};
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic start;
  assign start = (state == vpc_pkg::S_IDLE) && !multi && !stby &&
                 (next_cmd != vpc_pkg::CMD_NONE);
  chk_inc_step: assert property (
    start && next_cmd == vpc_pkg::CMD_INC && tap != 6'h00
    |=> tap == $past(tap) - 6'h01)
    else $error("increment did not step up one tap");
  chk_top_hold: assert property (
    start && next_cmd == vpc_pkg::CMD_INC && tap == 6'h00 |=> tap == 6'h00)
    else $error("top tap moved");
  chk_dec_step: assert property (
    start && next_cmd == vpc_pkg::CMD_DEC && tap != vpc_pkg::TAP_MUTE
    |=> tap == $past(tap) + 6'h01)
    else $error("decrement did not step down one tap");
  chk_bottom_hold: assert property (
    start && next_cmd != vpc_pkg::CMD_INC && !muted &&
    tap == vpc_pkg::TAP_MUTE |=> tap == vpc_pkg::TAP_MUTE)
    else $error("bottom tap moved");
  chk_mute_go: assert property (
    start && next_cmd == vpc_pkg::CMD_MUTE && !muted &&
    tap != vpc_pkg::TAP_MUTE
    |=> tap == vpc_pkg::TAP_MUTE && saved == $past(tap) && muted)
    else $error("mute did not park and remember");
  chk_mute_back: assert property (
    start && next_cmd == vpc_pkg::CMD_MUTE && muted
    |=> tap == $past(saved) && !muted)
    else $error("second mute did not restore");
  chk_standby_park: assert property (
    stby |=> LEFT_TAP == vpc_pkg::TAP_PARK &&
             RIGHT_TAP == vpc_pkg::TAP_PARK && !ARRAY_CONNECT && LOW_POWER)
    else $error("standby did not park wipers");
  chk_standby_back: assert property (
    !stby |=> LEFT_TAP == $past(wiper[0]) && ARRAY_CONNECT)
    else $error("wiper not restored after standby");
  chk_zc_apply: assert property (
    state == vpc_pkg::S_ZWAIT && !launch && pend[0] && zc2[0]
    |=> !pend[0] && wiper[0] == tap)
    else $error("left wiper missed zero crossing");
  chk_lock_time: assert property (
    $rose(state == vpc_pkg::S_HOLD) |-> lock_ms == 6'(vpc_pkg::LOCKOUT_MS))
    else $error("lockout shorter than its interval");
  chk_reset_tap: assert property (
    state == vpc_pkg::S_POWERUP |-> tap == vpc_pkg::TAP_RESET)
    else $error("reset tap wrong");
  chk_multi_drop: assert property (
    state == vpc_pkg::S_DISCARD |=> $stable(tap))
    else $error("discarded command moved tap");
  cov_mute: cover property (start && next_cmd == vpc_pkg::CMD_MUTE);
  cov_auto: cover property (state == vpc_pkg::S_HOLD && hold_ms >= due);
  cov_window: cover property (pend[1] && win_end);
endmodule
`default_nettype wire

/* tb/vpc_buttons.sv */
// push-button model: pulls the masked button pins low for a press
// assumes the bench calls press for one event at a time
`default_nettype none
module vpc_buttons #(
  parameter int TICK_CYCLES = 10
) (
  input  wire logic clk,
  output logic      inc_n,
  output logic      dec_n,
  output logic      mute_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // mask bit 0 inc, 1 dec, 2 mute; released pins pull high
  // ------------------------------------------------------------
  initial {mute_n, dec_n, inc_n} = 3'h7;
  task automatic press(input logic [2:0] m, input int ms);
    @(posedge clk);
    {mute_n, dec_n, inc_n} <= ~m;
    repeat (ms * TICK_CYCLES) @(posedge clk);
    {mute_n, dec_n, inc_n} <= 3'h7;
    repeat (100 * TICK_CYCLES) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb/vpc_top_bench.sv */
// self-checking bench for the push-button volume control
// assumes vpc_top scaled to 10 clocks per ms tick
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module vpc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 10;
  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  logic [7:0]                  adr = 8'h00;
  logic [31:0]                 wdat = 32'h0000_0000;
  logic                        we = 1'b0;
  logic                        cyc = 1'b0;
  logic                        stby_n = 1'b1;
  logic                        zl = 1'b1;
  logic                        zr = 1'b0;
  logic                        al = 1'b0;
  logic                        ar = 1'b0;
  logic [31:0]                 rdat;
  logic [31:0]                 q;
  logic                        ack;
  logic                        inc_n;
  logic                        dec_n;
  logic                        mute_n;
  logic [vpc_pkg::TAP_W-1:0]   ltap;
  logic [vpc_pkg::TAP_W-1:0]   rtap;
  logic                        conn;
  logic                        lowp;
  logic                        act;
  int                          fail_count = 0;
  int                          compares = 0;
  // ------------------------------------------------------------
  // design and button model
  // ------------------------------------------------------------
  vpc_top #(.TICK_CYCLES(TK)) dut (
    .SYS_CLK(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(4'h1), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .INC_BUTTON_N(inc_n),
    .DECREMENT_BUTTON_N(dec_n), .MUTE_BUTTON_N(mute_n),
    .STANDBY_N(stby_n), .LEFT_ZERO_CROSS(zl), .RIGHT_ZERO_CROSS(zr),
    .LEFT_ABOVE_THRESHOLD(al), .RIGHT_ABOVE_THRESHOLD(ar),
    .LEFT_TAP(ltap), .RIGHT_TAP(rtap), .ARRAY_CONNECT(conn),
    .LOW_POWER(lowp), .ACTIVITY(act));
  vpc_buttons #(.TICK_CYCLES(TK)) btn (
    .clk(clk), .inc_n(inc_n), .dec_n(dec_n), .mute_n(mute_n));
  // ------------------------------------------------------------
  // bus cycle, waits and verdict
  // ------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) fail_count++;
    cyc <= 1'b0;
  endtask
  task automatic ms(input int n);
    repeat (n * TK) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    complete_run;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    ms(15);
    `CHK({ltap, conn, lowp, act}, 9'h054)
    wb(1'b0, vpc_pkg::ADR_STATUS, 32'h0000_0000);
    `CHK(q[5:0], 6'h0a)
    wb(1'b0, 8'h08, 32'h0000_0000);
    `CHK(q, 32'h0000_0000)
    fork
      btn.press(3'h1, 25);
      begin
        ms(30);
        `CHK({ltap, rtap}, 12'h24a)
      end
    join
    `CHK({ltap, rtap}, 12'h249)
    zr <= 1'b1;
    btn.press(3'h1, 10);
    `CHK(ltap, 6'h09)
    btn.press(3'h2, 25);
    `CHK(ltap, 6'h0a)
    btn.press(3'h4, 25);
    `CHK({ltap, rtap}, 12'h820)
    wb(1'b0, vpc_pkg::ADR_STATUS, 32'h0000_0000);
    `CHK(q[9:0], 10'h060)
    btn.press(3'h2, 25);
    `CHK(ltap, 6'h20)
    btn.press(3'h4, 25);
    `CHK(rtap, 6'h0a)
    btn.press(3'h3, 25);
    `CHK(ltap, 6'h0a)
    stby_n <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK({ltap, conn, lowp}, 8'h81)
    wb(1'b0, vpc_pkg::ADR_STATUS, 32'h0000_0000);
    `CHK(q[9:0], 10'h10a)
    stby_n <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK({rtap, conn, lowp}, 8'h2a)
    btn.press(3'h1, 1100);
    `CHK(ltap, 6'h08)
    repeat (9) btn.press(3'h1, 25);
    `CHK(rtap, 6'h00)
    btn.press(3'h2, 1100);
    `CHK(ltap, 6'h02)
    wb(1'b1, vpc_pkg::ADR_CTRL, 32'h0000_0000);
    al <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(act, 1'b1)
    wb(1'b0, vpc_pkg::ADR_STATUS, 32'h0000_0000);
    `CHK(q[7], 1'b1)
    al <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(act, 1'b0)
    wb(1'b1, vpc_pkg::ADR_CTRL, 32'h0000_0001);
    ar <= 1'b1;
    repeat (40) @(posedge clk);
    ar <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK(act, 1'b1)
    wb(1'b0, vpc_pkg::ADR_CTRL, 32'h0000_0000);
    `CHK(q, 32'h0000_0001)
    complete_run;
  end
endmodule
`default_nettype wire
